// File: rtl/switch_fault_cfg.svh
// Constants for the eight-channel switch fault and status block.
// Assumes a 200 MHz system clock; times are converted to cycles here.
//
// Contract
// - Command bit zero turns its output on; one turns it off.
// - Status shifted out describes drain state from the previous command.
// - Over-temperature switches off only its own output, with no clock dependence; here it acts via the clocked synchroniser and only while clkEn is high.
// - Output shut by over-temperature reports off in its status bit.
// - After over-temperature clears, output stays off until next write requests on.
// - Over-voltage switches all outputs off until cleared and rewritten.
// - First write after over-voltage returns all ones status.
// - Open-load detection only on outputs commanded off, one detector each.
// - One drain threshold comparator serves open-load off and short on.
// - Chip select rise starts 25 to 100 us filter; comparator ignored meanwhile; here it masks only open-load, shortHit still drives currentLimit and status.
// - Open-load indication clears by itself when the condition goes.
// - Thermal limit in a short latches off only the faulted output.
// - Current limit within 20 us; on-state drain over threshold flags short.
// - Without fault, off output reads one and on output reads zero.
// - Chip select rise loads shift register into switches, starts delay timers.
// - Latch select low: short shuts output after delay; high: current limit.
`ifndef SWITCH_FAULT_CFG_SVH
`define SWITCH_FAULT_CFG_SVH
`define CLK_MHZ           200
`define FILTER_US         50
`define FILTER_CYC        (`FILTER_US * `CLK_MHZ)
`define TURNON_US         100
`define TURNON_CYC        (`TURNON_US * `CLK_MHZ)
`define CMD_RESET         8'hFF
`define STATUS_RESET      8'hFF
`define ALL_OFF           8'hFF
`define ALL_ON            8'h00
`define SYNC_RESET        20'h201FE
`define CNT_ZERO          16'h0000
`define CNT_ONE           16'h0001
`define CNT_MAX           65535
`endif

// File: rtl/switch_fault_pkg.sv
// Types for the eight-channel switch fault and status block.
// Assumes the constants header is included by the design file.
package switch_fault_pkg;
   typedef logic [7:0] chan_t;
endpackage

// File: rtl/octal_switch_fault_status.sv
// Fault detection, latching and status capture for eight low-side outputs.
// Assumes shift mechanics outside; detectors arrive as asynchronous levels.
`timescale 1ns/1ps
`include "switch_fault_cfg.svh"

module octal_switch_fault_status #(
   parameter int FILTER_CYCLES = `FILTER_CYC,
   parameter int TURNON_CYCLES = `TURNON_CYC
) (
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire logic                  clkEn,
   input  wire logic                  chipSelN,
   input  wire switch_fault_pkg::chan_t commandWord,
   input  wire switch_fault_pkg::chan_t drainThreshold,
   input  wire switch_fault_pkg::chan_t overTemp,
   input  wire logic                  loadSupplyOverVolt,
   input  wire logic                  shortFaultLatchSelect,
   output switch_fault_pkg::chan_t    switchOn,
   output switch_fault_pkg::chan_t    currentLimit,
   output switch_fault_pkg::chan_t    statusWord
);
   import switch_fault_pkg::*;

   if (FILTER_CYCLES < 1 || TURNON_CYCLES < 1 || FILTER_CYCLES > `CNT_MAX
       || TURNON_CYCLES > `CNT_MAX) begin : g_bad_counts
      $error("Timer counts out of range");
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] countDown(input logic [15:0] cnt);
      return (cnt != `CNT_ZERO) ? cnt - `CNT_ONE : `CNT_ZERO;
   endfunction

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [19:0] s1Reg, s2Reg, s3Reg, stableReg;
   logic [19:0] s1Next, s2Next, s3Next, stableNext;
   logic [19:0] rawIn;
   assign rawIn = {shortFaultLatchSelect, loadSupplyOverVolt, chipSelN,
                   overTemp, drainThreshold, 1'b0};

   always_comb begin
      s1Next     = rawIn;
      s2Next     = s1Reg;
      s3Next     = s2Reg;
      stableNext = stableReg;
      for (int i = 0; i < 20; i++) begin
         if (s2Reg[i] == s3Reg[i]) begin
            stableNext[i] = s3Reg[i];
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1Reg     <= `SYNC_RESET;
         s2Reg     <= `SYNC_RESET;
         s3Reg     <= `SYNC_RESET;
         stableReg <= `SYNC_RESET;
      end else if (clkEn) begin
         s1Reg     <= s1Next;
         s2Reg     <= s2Next;
         s3Reg     <= s3Next;
         stableReg <= stableNext;
      end
   end

   chan_t thrS, otS;
   logic  csS, ovS, latchSelS;
   assign thrS      = stableReg[8:1];
   assign otS       = stableReg[16:9];
   assign csS       = stableReg[17];
   assign ovS       = stableReg[18];
   assign latchSelS = stableReg[19];

   // ----------------------------------------------------------------
   // Switch control and fault state
   // ----------------------------------------------------------------
   logic        csPrevReg, csPrevNext;
   chan_t       cmdReg, cmdNext;
   chan_t       latchOffReg, latchOffNext;
   chan_t       onReg, onNext;
   chan_t       limReg, limNext;
   chan_t       statReg, statNext;
   logic        ovSeenReg, ovSeenNext;
   logic [15:0] filtCntReg, filtCntNext;
   logic [15:0] delayCntReg, delayCntNext;
   logic        csRise, csFall;
   chan_t       wantOn, openLoad, shortHit;

   assign csRise = csS && !csPrevReg;
   assign csFall = !csS && csPrevReg;

   always_comb begin
      csPrevNext   = csS;
      cmdNext      = cmdReg;
      latchOffNext = latchOffReg;
      ovSeenNext   = ovSeenReg || ovS;
      filtCntNext  = countDown(filtCntReg);
      delayCntNext = countDown(delayCntReg);
      statNext     = statReg;
      if (csRise) begin
         cmdNext      = commandWord;
         latchOffNext = 8'h00;
         filtCntNext  = FILTER_CYCLES[15:0];
         delayCntNext = TURNON_CYCLES[15:0];
      end
      wantOn   = ~cmdReg & ~latchOffReg;
      // Comparator low means drain below threshold
      openLoad = (filtCntReg == 16'h0000) ? (cmdReg & ~thrS) : 8'h00;
      shortHit = ~cmdReg & thrS;
      if (!latchSelS && delayCntReg == 16'h0000) begin
         latchOffNext = latchOffNext | (shortHit & ~{8{csRise}});
      end
      latchOffNext = latchOffNext | (otS & ~cmdReg & ~{8{csRise}});
      if (ovS) begin
         latchOffNext = `ALL_OFF;
      end
      onNext  = wantOn & ~otS & ~{8{ovS}};
      limNext = onNext & shortHit & {8{latchSelS}};
      if (csFall) begin
         if (ovSeenReg) begin
            statNext   = `ALL_OFF;
            ovSeenNext = ovS;
         end else begin
            // Off reads one, on reads zero; faults flip the bit
            statNext = ~onReg & ~openLoad | (onReg & shortHit);
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         csPrevReg   <= 1'b1;
         cmdReg      <= `CMD_RESET;
         latchOffReg <= 8'h00;
         onReg       <= 8'h00;
         limReg      <= 8'h00;
         statReg     <= `STATUS_RESET;
         ovSeenReg   <= 1'b0;
         filtCntReg  <= 16'h0000;
         delayCntReg <= 16'h0000;
      end else if (clkEn) begin
         csPrevReg   <= csPrevNext;
         cmdReg      <= cmdNext;
         latchOffReg <= latchOffNext;
         onReg       <= onNext;
         limReg      <= limNext;
         statReg     <= statNext;
         ovSeenReg   <= ovSeenNext;
         filtCntReg  <= filtCntNext;
         delayCntReg <= delayCntNext;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   assign switchOn     = onReg;
   assign currentLimit = limReg;
   assign statusWord   = statReg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_overvolt_all_off: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && ovS |=> switchOn == 8'h00) else $error("Outputs on during over-voltage");

   a_overtemp_off: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && otS[0] |=> !switchOn[0]) else $error("Hot output still on");

   a_command_off: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && cmdReg[3] |=> !switchOn[3]) else $error("Off command ignored");

   a_load_on_rise: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && csRise |=> cmdReg == $past(commandWord)) else $error("Command not loaded");

   a_filter_start: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && csRise |=> filtCntReg != 16'h0000) else $error("Filter not started");

   a_status_ff: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && csFall && ovSeenReg |=> statusWord == `ALL_OFF) else $error("No all-ones status");

   a_open_gate: assert property (@(posedge clk) disable iff (sys_rst)
      (openLoad & ~cmdReg) == 8'h00) else $error("Open-load on an on output");

   a_limit_mode: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && !latchSelS |=> currentLimit == 8'h00) else $error("Limit without select");

   a_short_latch: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && !latchSelS && delayCntReg == 16'h0000 && !csRise && shortHit[1]
      |=> latchOffReg[1]) else $error("Short not latched off");

   a_latch_clear: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && csRise && !ovS |=> latchOffReg == `ALL_ON) else $error("Latch not cleared");

   a_hot_latch: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && otS[5] && !cmdReg[5] && !csRise |=> latchOffReg[5]) else $error("Hot not held");

   a_status_hold: assert property (@(posedge clk) disable iff (sys_rst)
      !(clkEn && csFall) |=> $stable(statusWord)) else $error("Status moved off fall");

   a_open_filter: assert property (@(posedge clk) disable iff (sys_rst)
      filtCntReg != 16'h0000 |-> openLoad == 8'h00) else $error("Open-load in filter");

   a_limit_on: assert property (@(posedge clk) disable iff (sys_rst)
      (currentLimit & ~switchOn) == 8'h00) else $error("Limit on an off output");

   a_delay_start: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && csRise |=> delayCntReg != 16'h0000) else $error("Delay not started");

   a_delay_count: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && delayCntReg != 16'h0000 && !csRise
      |=> delayCntReg == $past(delayCntReg) - 16'h0001) else $error("Delay miscount");

   a_filter_count: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && filtCntReg != 16'h0000 && !csRise
      |=> filtCntReg == $past(filtCntReg) - 16'h0001) else $error("Filter miscount");

   a_ov_flag: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && ovS |=> ovSeenReg) else $error("Over-voltage not noted");
endmodule // octal_switch_fault_status

// File: bench/host_link_model.sv
// Host model: frames command words onto the switch block.
// Assumes the block samples the word at its synchronised select rise.
`timescale 1ns/1ps
module host_link_model (
   input  wire logic             clk,
   output logic                  chipSelN,
   output switch_fault_pkg::chan_t commandWord
);
   import switch_fault_pkg::*;
   initial begin
      chipSelN    = 1'b1;
      commandWord = 8'hA5;
   end
   task automatic frame(input chan_t cmd);
      @(posedge clk);
      chipSelN    <= 1'b0;
      commandWord <= cmd;
      repeat (16) @(posedge clk);
      chipSelN <= 1'b1;
      repeat (8) @(posedge clk);
      commandWord <= ~cmd;
   endtask
endmodule // host_link_model

// File: bench/octal_switch_fault_status_tb.sv
// Bench: host model frames words, the bench plays loads and detectors.
// Assumes filter and turn-on counts shortened to FILT cycles.
`timescale 1ns/1ps
module octal_switch_fault_status_tb;
   import switch_fault_pkg::*;
   localparam int FILT = 20;
   logic   clk, sys_rst, clkEn, chipSelN, loadSupplyOverVolt, shortFaultLatchSelect;
   chan_t  commandWord, drainThreshold, overTemp, switchOn, currentLimit, statusWord, expSt;
   chan_t  lastCmd, lastOn;
   int     fails, samples_checked;
   int     cycles = 0;
   integer seed = 32'h3C86;
   octal_switch_fault_status #(.FILTER_CYCLES(FILT), .TURNON_CYCLES(FILT))
      u_octal_switch_fault_status (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
      .chipSelN(chipSelN), .commandWord(commandWord), .drainThreshold(drainThreshold),
      .overTemp(overTemp), .loadSupplyOverVolt(loadSupplyOverVolt),
      .shortFaultLatchSelect(shortFaultLatchSelect), .switchOn(switchOn),
      .currentLimit(currentLimit), .statusWord(statusWord));
   host_link_model u_host_link_model (.clk(clk), .chipSelN(chipSelN),
      .commandWord(commandWord));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic check(input string what, input chan_t seen, input chan_t exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // --------------------------------------------------------------------
   // One frame, then loads and detectors as the model expects
   // --------------------------------------------------------------------
   task automatic step(input chan_t cmd, ot, open, short, input logic ov, sel);
      chan_t on;
      chan_t lim;
      u_host_link_model.frame(cmd);
      check("status", statusWord, expSt);
      check("fault xor", statusWord ^ lastCmd, expSt ^ lastCmd);
      lastCmd = cmd;
      on  = ~cmd & ~ot & ~{8{ov}} & ~(sel ? 8'h00 : short);
      lim = sel ? (short & on) : 8'h00;
      @(posedge clk);
      overTemp              <= ot;
      loadSupplyOverVolt    <= ov;
      shortFaultLatchSelect <= sel;
      drainThreshold        <= (~on & ~open) | short;
      repeat (3 * FILT) @(posedge clk);
      check("switchOn", switchOn, on);
      check("currentLimit", currentLimit, lim);
      overTemp           <= 8'h00;
      loadSupplyOverVolt <= 1'b0;
      repeat (FILT) @(posedge clk);
      check("held off", switchOn, on);
      lastOn = on;
      expSt  = ov ? 8'hFF : ((~on & ~open) | short);
   endtask
   initial begin
      sys_rst               = 1'b1;
      clkEn                 = 1'b1;
      overTemp              = 8'h00;
      loadSupplyOverVolt    = 1'b0;
      shortFaultLatchSelect = 1'b0;
      drainThreshold        = 8'hFF;
      expSt                 = 8'hFF;
      lastCmd               = 8'hFF;
      lastOn                = 8'h00;
      fails                 = 0;
      samples_checked       = 0;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      step(8'($random(seed)), 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
      step(8'h00, 8'h04, 8'h00, 8'h00, 1'b0, 1'b0);
      step(8'hF0, 8'h00, 8'h31, 8'h00, 1'b0, 1'b0);
      step(8'h00, 8'h00, 8'h00, 8'h02, 1'b0, 1'b0);
      step(8'h0F, 8'h00, 8'h00, 8'h10, 1'b0, 1'b1);
      step(8'h55, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0);
      for (int i = 0; i < 8; i++) begin
         step(8'($random(seed)), 8'h00, 8'h00, 8'h00, 1'b0, i[0]);
      end
      @(posedge clk);
      clkEn    <= 1'b0;
      overTemp <= 8'hFF;
      repeat (8) @(posedge clk);
      check("frozen", switchOn, lastOn);
      overTemp <= 8'h00;
      @(posedge clk);
      clkEn <= 1'b1;
      repeat (4) @(posedge clk);
      u_host_link_model.frame(8'hFF);
      check("last status", statusWord, expSt);
      test_done;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         test_done;
      end
   end
endmodule // octal_switch_fault_status_tb
